// ===== rtl/rfsi_regs.vh
// Register offsets, field positions, reset values and timing for the status block
`ifndef RFSI_REGS_VH
`define RFSI_REGS_VH

// Register offsets
`define RFSI_OFF_CHIP_CTRL 8'h00
`define RFSI_OFF_PROTO_CTRL 8'h01
`define RFSI_OFF_INT_STATUS 8'h0C
`define RFSI_OFF_COLL_HI_MASK 8'h0D
`define RFSI_OFF_COLL_LOW 8'h0E
`define RFSI_OFF_STRENGTH 8'h0F

// Interrupt status bit positions
`define RFSI_ST_TX 7
`define RFSI_ST_RX_START 6
`define RFSI_ST_FIFO 5
`define RFSI_ST_ERR1 4
`define RFSI_ST_ERR2 3
`define RFSI_ST_ERR3 2
`define RFSI_ST_COL 1
`define RFSI_ST_NORESP 0

// Control bit positions
`define RFSI_CHIP_SWAP_BIT 3
`define RFSI_PROTO_NO_CRC_BIT 7

// Strength register fields
`define RFSI_STR_OSC_BIT 6
`define RFSI_STR_AUX_LSB 3
`define RFSI_STR_MAIN_LSB 0

// Reset values
`define RFSI_RST_STATUS 8'h00
`define RFSI_RST_MASK 6'h3E
`define RFSI_RST_COLL 10'h000

// Timing
`define RFSI_CLK_MHZ 250
`define RFSI_OSC_STABLE_US 200

`endif

// ===== rtl/rfsi_peak_hold.v
// Peak hold of one receive channel strength code
`timescale 1ns/1ps
module rfsi_peak_hold #(
   parameter WIDTH = 3
) (
   // Clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // Control
   input wire clear_i,
   input wire sample_i,
   input wire [WIDTH-1:0] level_i,
   // Result
   output reg [WIDTH-1:0] peak_o
);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         peak_o <= {WIDTH{1'b0}};
      end else if (clear_i) begin
         peak_o <= {WIDTH{1'b0}}; // R20
      end else if (sample_i && (level_i > peak_o)) begin
         peak_o <= level_i; // R20
      end
   end

endmodule

// ===== rtl/rfsi_status_irq.v
// Interrupt status, mask, collision position and strength registers
//
// Function
// R1: Status clears at reset, enable low, protocol write
// R2: Status read clears bits and drops IRQ
// R3: Transmit bit set at start, IRQ at end
// R4: Receive bit set at start of frame
// R5: FIFO bit flags fill crossing thirds
// R6: Reader CRC error only when CRC enabled
// R7: Reader parity and framing error bits
// R8: Collision when subcarrier pulses exceed limit
// R9: No-response bit when wait time expires
// R10: Transmit: decoder off, only FIFO/transmit change
// R11: Receive: only B6 changes; IRQ at phase ends
// R12: NFC protocol error and detection done bits
// R13: NFC field reached or lost sets bit
// R14: NFC collision avoidance done or failed bits
// R15: Mask enables, reset value 0x3E
// R16: Ten-bit collision position, cleared on read
// R17: Non-Type-A protocols report error position
// R18: Oscillator stable after about 200 us
// R19: Aux and main strength codes
// R20: Peak latched, reset at next transmission
// R21: Swap bit exchanges receive inputs
// R22: Masked events set status without IRQ
`timescale 1ns/1ps
`include "rfsi_regs.vh"
module rfsi_status_irq #(
   parameter FIFO_DEPTH = 128,
   parameter OSC_STABLE_CYCLES = `RFSI_OSC_STABLE_US * `RFSI_CLK_MHZ
) (
   // Clock and reset
   input wire clock_i,
   input wire rst_n_i,
   input wire enable_i,
   // Host register port
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   output reg irq_o,
   // Mode
   input wire nfc_mode_i,
   input wire type_a_i,
   input wire rate_106_i,
   input wire col_six_pulses_i,
   // Transceiver phases
   input wire tx_start_i,
   input wire tx_end_i,
   input wire rx_sof_i,
   input wire rx_end_i,
   // FIFO
   input wire [7:0] fifo_count_i,
   // Reader events
   input wire crc_err_i,
   input wire parity_err_i,
   input wire framing_err_i,
   input wire [3:0] pulse_count_i,
   input wire bit_period_end_i,
   input wire noresp_expired_i,
   input wire [9:0] err_pos_i,
   // NFC events
   input wire protocol_err_i,
   input wire sdd_done_i,
   input wire field_ok_i,
   input wire ca_done_i,
   input wire ca_fail_i,
   // Oscillator and strength
   input wire osc_run_i,
   input wire [2:0] main_rx_input_i,
   input wire [2:0] aux_rx_input_i
);

   localparam PH_IDLE = 2'b00;
   localparam PH_TX = 2'b01;
   localparam PH_RX = 2'b10;

   reg [1:0] phase;
   reg [1:0] next_phase;
   reg [7:0] status;
   reg [7:0] next_status;
   reg [5:0] pend;
   reg [5:0] next_pend;
   reg [5:0] mask;
   reg [9:0] coll_pos;
   reg [9:0] next_coll_pos;
   reg swap;
   reg no_crc;
   reg field_prev;
   reg [1:0] fifo_zone;
   reg [16:0] osc_cnt;
   reg osc_ok;
   reg next_irq;
   reg [5:0] ev;
   reg [1:0] zone_now;
   reg collide;
   reg pos_hit;
   wire [2:0] ch_level [0:1];
   wire [2:0] ch_peak [0:1];
   wire wr_proto;
   wire rd_status;
   wire rd_hi;
   wire rd_low;
   wire clear_all;

   assign wr_proto = reg_wr_i && (reg_addr_i == `RFSI_OFF_PROTO_CTRL);
   assign rd_status = reg_rd_i && (reg_addr_i == `RFSI_OFF_INT_STATUS);
   assign rd_hi = reg_rd_i && (reg_addr_i == `RFSI_OFF_COLL_HI_MASK);
   assign rd_low = reg_rd_i && (reg_addr_i == `RFSI_OFF_COLL_LOW);
   assign clear_all = !enable_i || wr_proto; // R1

   // Receive input swap
   assign ch_level[0] = swap ? aux_rx_input_i : main_rx_input_i; // R21
   assign ch_level[1] = swap ? main_rx_input_i : aux_rx_input_i; // R21

   // Strength peak per channel
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_peak
         rfsi_peak_hold #(
            .WIDTH(3)
         ) u_peak (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .clear_i(tx_start_i),
            .sample_i(phase != PH_TX),
            .level_i(ch_level[gi]),
            .peak_o(ch_peak[gi])
         );
      end
   endgenerate

   // FIFO fill zone: 2 high, 1 low, 0 middle
   always @* begin
      zone_now = 2'd0;
      if ({2'b00, fifo_count_i} * 10'd3 > FIFO_DEPTH * 2) begin
         zone_now = 2'd2;
      end else if ({2'b00, fifo_count_i} * 10'd3 < FIFO_DEPTH) begin
         zone_now = 2'd1;
      end
   end

   // Event decode for bits B4 to B0 plus FIFO
   always @* begin
      ev = 6'h00;
      collide = 1'b0;
      if (zone_now != fifo_zone && zone_now != 2'd0) begin
         ev[5] = 1'b1; // R5
      end
      if (nfc_mode_i) begin
         ev[4] = protocol_err_i; // R12
         ev[3] = sdd_done_i && rate_106_i; // R12
         ev[2] = field_ok_i != field_prev; // R13
         ev[1] = ca_done_i; // R14
         ev[0] = ca_fail_i; // R14
      end else begin
         ev[4] = crc_err_i && !no_crc; // R6
         ev[3] = parity_err_i && type_a_i; // R7
         ev[2] = framing_err_i; // R7
         if (type_a_i && rate_106_i && bit_period_end_i) begin
            collide = col_six_pulses_i ? (pulse_count_i > 4'd6) : (pulse_count_i > 4'd7); // R8
         end
         ev[1] = collide; // R8
         ev[0] = noresp_expired_i; // R9
      end
   end

   // Phase tracking
   always @* begin
      next_phase = phase;
      case (phase)
         PH_IDLE: begin
            if (tx_start_i) begin
               next_phase = PH_TX;
            end else if (rx_sof_i) begin
               next_phase = PH_RX;
            end
         end
         PH_TX: begin
            if (tx_end_i) begin
               next_phase = PH_IDLE;
            end
         end
         PH_RX: begin
            if (rx_end_i) begin
               next_phase = PH_IDLE;
            end
         end
         default: begin
            next_phase = PH_IDLE;
         end
      endcase
      if (clear_all) begin
         next_phase = PH_IDLE;
      end
   end

   // Status, pending and IRQ update; sets win over read clear
   always @* begin
      next_status = status;
      next_pend = pend;
      next_irq = irq_o;
      if (rd_status) begin
         next_status = `RFSI_RST_STATUS; // R2
         next_irq = 1'b0; // R2
      end
      case (phase)
         PH_TX: begin
            if (ev[5]) begin
               next_status[`RFSI_ST_FIFO] = 1'b1; // R10
               if (mask[5]) begin
                  next_irq = 1'b1; // R22
               end
            end
            if (tx_end_i) begin
               next_irq = 1'b1; // R3
            end
         end
         PH_RX: begin
            next_pend = pend | ev; // R11
            if (rx_end_i) begin
               next_status[5:0] = next_status[5:0] | pend | ev;
               next_irq = 1'b1; // R11
            end
         end
         default: begin
            next_status[5:0] = next_status[5:0] | ev;
            if ((ev & mask) != 6'h00) begin
               next_irq = 1'b1; // R22
            end
            if (tx_start_i) begin
               next_status[`RFSI_ST_TX] = 1'b1; // R3
            end
            if (rx_sof_i && !tx_start_i) begin
               next_status[`RFSI_ST_RX_START] = 1'b1; // R4
               next_pend = 6'h00;
            end
         end
      endcase
      if (clear_all) begin
         next_status = `RFSI_RST_STATUS; // R1
         next_pend = 6'h00;
         next_irq = 1'b0;
      end
   end

   // Collision or error position capture
   always @* begin
      pos_hit = 1'b0;
      if (phase != PH_TX) begin
         pos_hit = type_a_i ? collide : (ev[4] | ev[3] | ev[2]); // R17
      end
      next_coll_pos = coll_pos;
      if (rd_hi) begin
         next_coll_pos[9:8] = 2'b00; // R16
      end
      if (rd_low) begin
         next_coll_pos[7:0] = 8'h00; // R16
      end
      if (pos_hit) begin
         next_coll_pos = err_pos_i; // R16
      end
      if (!enable_i) begin
         next_coll_pos = `RFSI_RST_COLL;
      end
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= PH_IDLE;
         status <= `RFSI_RST_STATUS; // R1
         pend <= 6'h00;
         irq_o <= 1'b0;
         coll_pos <= `RFSI_RST_COLL;
         field_prev <= 1'b0;
         fifo_zone <= 2'd1; // R5
      end else begin
         phase <= next_phase;
         status <= next_status;
         pend <= next_pend;
         irq_o <= next_irq; // R11
         coll_pos <= next_coll_pos;
         field_prev <= field_ok_i;
         fifo_zone <= zone_now;
      end
   end

   // Control registers
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask <= `RFSI_RST_MASK; // R15
         swap <= 1'b0;
         no_crc <= 1'b0;
      end else if (!enable_i) begin
         mask <= `RFSI_RST_MASK; // R15
         swap <= 1'b0;
         no_crc <= 1'b0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `RFSI_OFF_COLL_HI_MASK) begin
            mask <= reg_wdata_i[5:0]; // R15
         end
         if (reg_addr_i == `RFSI_OFF_CHIP_CTRL) begin
            swap <= reg_wdata_i[`RFSI_CHIP_SWAP_BIT]; // R21
         end
         if (wr_proto) begin
            no_crc <= reg_wdata_i[`RFSI_PROTO_NO_CRC_BIT]; // R6
         end
      end
   end

   // Oscillator settle counter
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_cnt <= 17'd0;
         osc_ok <= 1'b0;
      end else if (!osc_run_i) begin
         osc_cnt <= 17'd0;
         osc_ok <= 1'b0;
      end else if (osc_cnt >= OSC_STABLE_CYCLES[16:0] - 17'd1) begin
         osc_ok <= 1'b1; // R18
      end else begin
         osc_cnt <= osc_cnt + 17'd1;
      end
   end

   // Read data
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `RFSI_OFF_INT_STATUS: begin
               reg_rdata_o <= status;
            end
            `RFSI_OFF_COLL_HI_MASK: begin
               reg_rdata_o <= {coll_pos[9:8], mask};
            end
            `RFSI_OFF_COLL_LOW: begin
               reg_rdata_o <= coll_pos[7:0];
            end
            `RFSI_OFF_STRENGTH: begin
               reg_rdata_o <= {1'b0, osc_ok, ch_peak[1], ch_peak[0]}; // R19
            end
            default: begin
               reg_rdata_o <= 8'h00;
            end
         endcase
      end
   end

endmodule

// ===== test/rfsi_host_model.sv
// Host side model driving the register port
`timescale 1ns/1ps
module rfsi_host_model (
   // Clock
   input wire clock_i,
   // Register port
   input wire [7:0] reg_rdata_i,
   output reg [7:0] reg_addr_o,
   output reg reg_wr_o,
   output reg reg_rd_o,
   output reg [7:0] reg_wdata_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
   end
   task wr(input [7:0] a, input [7:0] dat);
      begin
         @(posedge clock_i);
         reg_addr_o <= a;
         reg_wdata_o <= dat;
         reg_wr_o <= 1'b1;
         @(posedge clock_i);
         reg_wr_o <= 1'b0;
         reg_addr_o <= ~a;
         reg_wdata_o <= ~dat;
      end
   endtask
   // Status read acknowledges an interrupt
   task rd(input [7:0] a, output [7:0] dat);
      begin
         @(posedge clock_i);
         reg_addr_o <= a;
         reg_rd_o <= 1'b1;
         @(posedge clock_i);
         reg_rd_o <= 1'b0;
         reg_addr_o <= ~a;
         #1 dat = reg_rdata_i;
      end
   endtask
endmodule

// ===== test/rfsi_status_irq_sva.sv
// Assertions on the status block ports
`timescale 1ns/1ps
module rfsi_status_irq_sva (
   // Clock and reset
   input wire clock_i,
   input wire rst_n_i,
   input wire enable_i,
   // Register port
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire irq_o,
   // Events
   input wire tx_start_i,
   input wire tx_end_i,
   input wire rx_sof_i,
   input wire rx_end_i,
   input wire [7:0] fifo_count_i,
   input wire crc_err_i,
   input wire parity_err_i,
   input wire framing_err_i,
   input wire bit_period_end_i,
   input wire noresp_expired_i,
   input wire protocol_err_i,
   input wire sdd_done_i,
   input wire field_ok_i,
   input wire ca_done_i,
   input wire ca_fail_i
);
   reg in_tx;
   reg in_rx;
   wire wr01 = reg_wr_i && reg_addr_i == 8'h01;
   wire quiet = !(tx_end_i | rx_end_i | crc_err_i | parity_err_i | framing_err_i |
      bit_period_end_i | noresp_expired_i | protocol_err_i | sdd_done_i | ca_done_i | ca_fail_i);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_tx <= 1'b0;
         in_rx <= 1'b0;
      end else begin
         in_tx <= enable_i & !wr01 & (tx_start_i & !in_rx | in_tx & !tx_end_i);
         in_rx <= enable_i & !wr01 & (rx_sof_i & !in_tx & !tx_start_i | in_rx & !rx_end_i);
      end
   end
   a_enable_clears_irq: assert property (!enable_i |=> !irq_o)
      else $error("irq high after enable low");
   a_proto_wr_clear: assert property (wr01 |=> !irq_o)
      else $error("irq high after protocol write");
   a_read_drops_irq: assert property (reg_rd_i && reg_addr_i == 8'h0C && quiet &&
      $stable(fifo_count_i) && $stable(field_ok_i) |=> !irq_o)
      else $error("irq kept after status read");
   a_irq_needs_event: assert property (!irq_o && quiet && $stable(fifo_count_i) &&
      $stable(field_ok_i) |=> !irq_o)
      else $error("irq rose without event");
   a_tx_end_irq: assert property (in_tx && tx_end_i && enable_i && !wr01 |=> irq_o)
      else $error("no irq at end of transmit");
   a_rx_end_irq: assert property (in_rx && rx_end_i && enable_i && !wr01 |=> irq_o)
      else $error("no irq at end of receive");
   a_rx_silent: assert property (in_rx && !rx_end_i && !irq_o |=> !irq_o)
      else $error("irq during receive");
   a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data changed without read");
   a_str_top_zero: assert property (reg_rd_i && reg_addr_i == 8'h0F |=> !reg_rdata_o[7])
      else $error("strength bit 7 not zero");
endmodule
bind rfsi_status_irq rfsi_status_irq_sva rfsi_status_irq_sva_i (.*);

// ===== test/rfsi_status_irq_tb_top.sv
// Testbench for the status and interrupt block
`timescale 1ns/1ps
module rfsi_status_irq_tb_top;
   localparam [26:0] BITS = {3'd0, 3'd1, 3'd3, 3'd4, 3'd1, 3'd0, 3'd2, 3'd3, 3'd4};
   reg clock_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg enable_i = 1'b1;
   reg nfc = 1'b0;
   reg type_a = 1'b0;
   reg osc = 1'b1;
   reg field = 1'b0;
   reg [7:0] fifo = 8'h00;
   reg [12:0] p = 13'h0000;
   reg [2:0] main_in = 3'h3;
   reg [2:0] aux_in = 3'h5;
   reg rate106 = 1'b1;
   reg col6 = 1'b1;
   reg [3:0] pcount = 4'h7;
   reg [9:0] errpos = 10'h2A5;
   reg [7:0] d;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, irq;
   integer num_errors = 0;
   integer cmp_count = 0;
   integer i;
   always #2 clock_i = ~clock_i;
   rfsi_host_model rfsi_host_model_i (.clock_i(clock_i), .reg_rdata_i(rdata),
      .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
   rfsi_status_irq #(.OSC_STABLE_CYCLES(20)) rfsi_status_irq_i (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .enable_i(enable_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_o(irq),
      .nfc_mode_i(nfc), .type_a_i(type_a), .rate_106_i(rate106), .col_six_pulses_i(col6),
      .tx_start_i(p[9]), .tx_end_i(p[10]), .rx_sof_i(p[11]), .rx_end_i(p[12]),
      .fifo_count_i(fifo), .crc_err_i(p[0]), .parity_err_i(p[1]), .framing_err_i(p[2]),
      .pulse_count_i(pcount), .bit_period_end_i(p[4]), .noresp_expired_i(p[3]),
      .err_pos_i(errpos), .protocol_err_i(p[5]), .sdd_done_i(p[6]), .field_ok_i(field),
      .ca_done_i(p[7]), .ca_fail_i(p[8]), .osc_run_i(osc), .main_rx_input_i(main_in),
      .aux_rx_input_i(aux_in));
   task report_and_stop;
      begin
         if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task pulse(input integer k);
      begin
         @(posedge clock_i);
         p[k] <= 1'b1;
         @(posedge clock_i);
         p[k] <= 1'b0;
         #1;
      end
   endtask
   task rchk(input [7:0] a, input [7:0] exp);
      begin
         rfsi_host_model_i.rd(a, d);
         chk("register", d, exp);
      end
   endtask
   initial begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rfsi_host_model_i.rd(8'h0F, d);
      chk("osc", d & 8'hC0, 8'h00);
      rchk(8'h0C, 8'h00);
      rchk(8'h0D, 8'h3E);
      rchk(8'h0E, 8'h00);
      rchk(8'h20, 8'h00);
      pulse(9);
      pulse(0);
      chk("irq", {7'h00, irq}, 8'h00);
      pulse(10);
      chk("irq", {7'h00, irq}, 8'h01);
      rchk(8'h0C, 8'h80);
      chk("irq", {7'h00, irq}, 8'h00);
      pulse(11);
      pulse(0);
      chk("irq", {7'h00, irq}, 8'h00);
      pulse(12);
      chk("irq", {7'h00, irq}, 8'h01);
      rchk(8'h0C, 8'h50);
      rchk(8'h0D, 8'hBE);
      rchk(8'h0E, 8'hA5);
      rchk(8'h0E, 8'h00);
      for (i = 0; i < 9; i = i + 1) begin
         @(posedge clock_i);
         nfc <= (i > 4);
         type_a <= 1'b1;
         pulse(i);
         chk("irq", {7'h00, irq}, {7'h00, BITS[3*i +: 3] != 3'd0});
         rchk(8'h0C, 8'h01 << BITS[3*i +: 3]);
      end
      @(posedge clock_i);
      field <= 1'b1;
      rchk(8'h0C, 8'h04);
      @(posedge clock_i);
      nfc <= 1'b0;
      rfsi_host_model_i.wr(8'h01, 8'h80);
      pulse(0);
      rchk(8'h0C, 8'h00);
      pulse(1);
      rfsi_host_model_i.wr(8'h01, 8'h00);
      @(posedge clock_i);
      #1 chk("irq", {7'h00, irq}, 8'h00);
      rchk(8'h0C, 8'h00);
      rfsi_host_model_i.wr(8'h0D, 8'hFF);
      rchk(8'h0D, 8'hBF);
      pulse(3);
      chk("irq", {7'h00, irq}, 8'h01);
      rchk(8'h0C, 8'h01);
      @(posedge clock_i);
      fifo <= 8'd100;
      repeat (2) @(posedge clock_i);
      #1 chk("irq", {7'h00, irq}, 8'h01);
      rchk(8'h0C, 8'h20);
      @(posedge clock_i);
      fifo <= 8'd20;
      rchk(8'h0C, 8'h20);
      rfsi_host_model_i.wr(8'h0D, 8'h00);
      pulse(1);
      chk("irq", {7'h00, irq}, 8'h00);
      rchk(8'h0C, 8'h08);
      rchk(8'h0F, 8'h6B);
      @(posedge clock_i);
      main_in <= 3'h1;
      rfsi_host_model_i.wr(8'h00, 8'h08);
      rchk(8'h0F, 8'h6D);
      pulse(9);
      pulse(10);
      rchk(8'h0F, 8'h4D);
      rchk(8'h0C, 8'h80);
      @(posedge clock_i);
      col6 <= 1'b0;
      osc <= 1'b0;
      pulse(4);
      rchk(8'h0C, 8'h00);
      rchk(8'h0F, 8'h0D);
      @(posedge clock_i);
      pcount <= 4'h8;
      errpos <= 10'h1C3;
      pulse(4);
      rchk(8'h0C, 8'h02);
      rchk(8'h0E, 8'hC3);
      rchk(8'h0D, 8'h40);
      @(posedge clock_i);
      nfc <= 1'b1;
      rate106 <= 1'b0;
      pulse(6);
      @(posedge clock_i);
      field <= 1'b0;
      rchk(8'h0C, 8'h04);
      @(posedge clock_i);
      nfc <= 1'b0;
      type_a <= 1'b0;
      pulse(1);
      rchk(8'h0C, 8'h00);
      @(posedge clock_i);
      enable_i <= 1'b0;
      @(posedge clock_i);
      enable_i <= 1'b1;
      rchk(8'h0C, 8'h00);
      rchk(8'h0D, 8'h3E);
      report_and_stop;
   end
   initial begin
      #40000;
      num_errors = num_errors + 1;
      report_and_stop;
   end
endmodule
